// ==== hw/qei_consts.vh ====
/*
 * Shared constants for the quadrature encoder block: event bit
 * positions, reset values and predivider codes.
 * Assumes inclusion by bare name from files under hw/.
 */
`ifndef QEI_CONSTS_VH
`define QEI_CONSTS_VH

// ****************************************************************
// Event bit positions
// ****************************************************************
`define EVT_PHASE_ERROR 0
`define EVT_DIRECTION 1
`define EVT_VEL_TIMER 2
`define EVT_INDEX 3
`define EVT_COUNT 4

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define POS_WIDTH 32
`define VEL_WIDTH 32
`define PREDIV_WIDTH 3
`define POS_RESET 32'h0000_0000
`define VEL_RESET 32'h0000_0000
`define PREDIV_MAX 3'h7

`endif

// ==== hw/qei_sync2.v ====
/*
 * Two flip-flop synchroniser for a bus of asynchronous levels.
 * Assumes inputs come from pins outside the sys_clk_i domain.
 */
`timescale 1ns/1ps

module qei_sync2 #(
    parameter WIDTH = 3
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rstn_i,
    // Data
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // First stage is read only by the second
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule

// ==== hw/qei_core.v ====
/*
 * Quadrature encoder interface: position integrator, velocity
 * capture, sticky events with per-source enables and one interrupt.
 * Assumes encoder pins are asynchronous and software settings come
 * from logic on sys_clk_i, held stable while in use.
 */
// Operation
// - Per-source enables gate interrupt line
// - Raw and masked status both readable
// - Position readable; index alignment after first pulse
// - Position write loads counter, counting continues
// - Power-of-two predivider, 1 to 128
// - Accumulate over period, store, clear
// - Velocity enable separate, clearing stops accumulation
// - No velocity capture while module disabled
// - Velocity equals last completed period count
// - Both inputs changing flags phase error in quadrature decode only
// - Count channel A edges or both
// - Index reset: zero forward, limit reverse
// - Quadrature or clock-direction, optional swap
`timescale 1ns/1ps
`include "qei_consts.vh"

module qei_core #(
    parameter POS_W = `POS_WIDTH,
    parameter VEL_W = `VEL_WIDTH
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rstn_i,
    // Encoder pins
    input wire phase_a_input_i,
    input wire phase_b_input_i,
    input wire index_i,
    // Configuration
    input wire module_enable_i,
    input wire count_both_channels_i,
    input wire reset_on_index_i,
    input wire clock_direction_decode_i,
    input wire channel_swap_i,
    input wire [POS_W-1:0] position_upper_limit_i,
    // Position load
    input wire position_load_i,
    input wire [POS_W-1:0] position_load_value_i,
    // Velocity settings
    input wire velocity_enable_i,
    input wire [`PREDIV_WIDTH-1:0] velocity_predivider_i,
    input wire [VEL_W-1:0] velocity_period_ticks_i,
    // Event enables and clearing
    input wire [`EVT_COUNT-1:0] event_enable_i,
    input wire [`EVT_COUNT-1:0] event_clear_i,
    input wire masked_status_select_i,
    // Status
    output wire [POS_W-1:0] position_o,
    output wire [VEL_W-1:0] velocity_o,
    output wire direction_o,
    output wire phase_error_o,
    output wire index_seen_o,
    output wire [`EVT_COUNT-1:0] raw_status_o,
    output wire [`EVT_COUNT-1:0] masked_status_o,
    output wire [`EVT_COUNT-1:0] status_o,
    output wire irq_o
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    wire [2:0] pins_s;
    reg [2:0] pins_prev_r;
    wire a_raw;
    wire b_raw;
    wire a_cur;
    wire b_cur;
    wire a_old;
    wire b_old;
    wire idx_rise;

    qei_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .async_i({index_i, phase_b_input_i, phase_a_input_i}),
        .sync_o(pins_s)
    );

    // Previous sample for edge detection
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pins_prev_r <= 3'h0;
        else
            pins_prev_r <= pins_s;
    end

    // Optional channel swap ahead of decoding
    assign a_cur = channel_swap_i ? pins_s[1] : pins_s[0];
    assign b_cur = channel_swap_i ? pins_s[0] : pins_s[1];
    assign a_old = channel_swap_i ? pins_prev_r[1] : pins_prev_r[0];
    assign b_old = channel_swap_i ? pins_prev_r[0] : pins_prev_r[1];
    assign a_raw = a_cur ^ a_old;
    assign b_raw = b_cur ^ b_old;
    assign idx_rise = pins_s[2] & ~pins_prev_r[2];

    // ************************************************************
    // Decoder
    // ************************************************************
    reg step;
    reg step_fwd;
    reg phase_err;

    // Step and direction from either decode mode
    always @*
    begin
        step = 1'b0;
        step_fwd = 1'b1;
        phase_err = 1'b0;
        if (clock_direction_decode_i)
        begin
            // A is clock, B is direction level
            step = a_cur & ~a_old;
            step_fwd = ~b_cur;
            if (count_both_channels_i)
                step = a_raw;
        end
        else if (a_raw && b_raw)
            phase_err = 1'b1;
        else if (a_raw)
        begin
            step = 1'b1;
            step_fwd = a_cur ^ b_cur;
        end
        else if (b_raw)
        begin
            step = count_both_channels_i;
            step_fwd = ~(a_cur ^ b_cur);
        end
    end

    // ************************************************************
    // Position integrator
    // ************************************************************
    reg [POS_W-1:0] pos_r;
    reg dir_r;
    reg idx_seen_r;
    wire active;
    wire dir_change;

    assign active = module_enable_i;
    assign dir_change = active & step & (step_fwd != dir_r);

    // Counting, index reset and software load
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pos_r <= `POS_RESET;
            dir_r <= 1'b1;
            idx_seen_r <= 1'b0;
        end
        else
        begin
            if (!reset_on_index_i)
                idx_seen_r <= 1'b0;
            else if (active && idx_rise)
                idx_seen_r <= 1'b1;
            if (active && step)
                dir_r <= step_fwd;
            if (position_load_i)
                pos_r <= position_load_value_i;
            else if (active && reset_on_index_i && idx_rise)
                pos_r <= dir_r ? {POS_W{1'b0}}
                               : position_upper_limit_i;
            else if (active && step)
            begin
                if (step_fwd)
                    pos_r <= (pos_r >= position_upper_limit_i)
                        ? {POS_W{1'b0}} : pos_r + 1'b1;
                else
                    pos_r <= (pos_r == {POS_W{1'b0}})
                        ? position_upper_limit_i : pos_r - 1'b1;
            end
        end
    end

    // ************************************************************
    // Velocity capture
    // ************************************************************
    reg [6:0] div_r;
    reg [VEL_W-1:0] acc_r;
    reg [VEL_W-1:0] tick_r;
    reg [VEL_W-1:0] vel_r;
    wire vel_run;
    wire [6:0] div_mask;
    wire div_pulse;
    wire period_end;

    assign vel_run = velocity_enable_i & module_enable_i;
    // Mask of 2^n - 1 for division by 2^n
    assign div_mask = ~(7'h7f << velocity_predivider_i);
    assign div_pulse = step & ((div_r & div_mask) == div_mask);
    // Period length relies on a non-zero setting
    assign period_end = (tick_r >= velocity_period_ticks_i - 1'b1);

    // Predivider, tick counter and accumulator
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            div_r <= 7'h00;
            acc_r <= `VEL_RESET;
            tick_r <= {VEL_W{1'b0}};
            vel_r <= `VEL_RESET;
        end
        else if (!vel_run)
        begin
            // Stopped: restart cleanly on next enable
            div_r <= 7'h00;
            acc_r <= {VEL_W{1'b0}};
            tick_r <= {VEL_W{1'b0}};
        end
        else
        begin
            if (step)
                div_r <= div_pulse ? 7'h00 : div_r + 1'b1;
            if (period_end)
            begin
                // Store count including this cycle's pulse
                vel_r <= acc_r + {{(VEL_W-1){1'b0}}, div_pulse};
                acc_r <= {VEL_W{1'b0}};
                tick_r <= {VEL_W{1'b0}};
            end
            else
            begin
                if (div_pulse)
                    acc_r <= acc_r + 1'b1;
                tick_r <= tick_r + 1'b1;
            end
        end
    end

    // ************************************************************
    // Events and interrupt
    // ************************************************************
    reg [`EVT_COUNT-1:0] evt_r;
    reg err_flag_r;
    wire [`EVT_COUNT-1:0] evt_set;

    assign evt_set[`EVT_PHASE_ERROR] = active & phase_err;
    assign evt_set[`EVT_DIRECTION] = dir_change;
    assign evt_set[`EVT_VEL_TIMER] = vel_run & period_end;
    assign evt_set[`EVT_INDEX] = active & idx_rise;

    // Sticky flags, set wins over write-one-to-clear
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            evt_r <= {`EVT_COUNT{1'b0}};
            err_flag_r <= 1'b0;
        end
        else
        begin
            evt_r <= (evt_r & ~event_clear_i) | evt_set;
            if (evt_set[`EVT_PHASE_ERROR])
                err_flag_r <= 1'b1;
            else if (event_clear_i[`EVT_PHASE_ERROR])
                err_flag_r <= 1'b0;
        end
    end

    assign raw_status_o = evt_r;
    assign masked_status_o = evt_r & event_enable_i;
    assign status_o = masked_status_select_i ? masked_status_o
                                             : raw_status_o;
    assign irq_o = |masked_status_o;
    assign position_o = pos_r;
    assign velocity_o = vel_r;
    assign direction_o = dir_r;
    assign phase_error_o = err_flag_r;
    assign index_seen_o = idx_seen_r;

endmodule

// ==== dv/qei_enc_model.sv ====
/* Encoder model: gray-coded phases, index pulse, glitch.
   Assumes tasks are called from the sys_clk_i domain. */
`timescale 1ns/1ps
module qei_enc_model (
    // Clock
    input wire logic sys_clk_i,
    // Encoder pins
    output logic phase_a_o,
    output logic phase_b_o,
    output logic index_o
);
    logic [1:0] st_r = 2'h0;
    initial index_o = 1'b0;
    // Gray phases, one pin changes per step
    assign phase_a_o = st_r[0] ^ st_r[1];
    assign phase_b_o = st_r[1];
    // One step either way
    task step(input bit fwd);
        @(posedge sys_clk_i);
        st_r <= fwd ? st_r + 2'h1 : st_r - 2'h1;
    endtask
    // Both pins at once
    task glitch;
        @(posedge sys_clk_i);
        st_r <= st_r + 2'h2;
    endtask
    // Short index pulse
    task idx;
        @(posedge sys_clk_i);
        index_o <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        index_o <= 1'b0;
    endtask
endmodule

// ==== dv/qei_core_chk.sv ====
/* Checker for qei_core port relations.
   Assumes bind to qei_core and hw/ on the include path. */
`timescale 1ns/1ps
`include "qei_consts.vh"
module qei_core_chk #(
    parameter POS_W = 32,
    parameter VEL_W = 32
) (
    // Clock, reset, inputs
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic module_enable_i,
    input wire logic position_load_i,
    input wire logic [POS_W-1:0] position_load_value_i,
    input wire logic velocity_enable_i,
    input wire logic [`EVT_COUNT-1:0] event_enable_i,
    input wire logic [`EVT_COUNT-1:0] event_clear_i,
    input wire logic masked_status_select_i,
    // Outputs
    input wire logic [POS_W-1:0] position_o,
    input wire logic [VEL_W-1:0] velocity_o,
    input wire logic phase_error_o,
    input wire logic [`EVT_COUNT-1:0] raw_status_o,
    input wire logic [`EVT_COUNT-1:0] masked_status_o,
    input wire logic [`EVT_COUNT-1:0] status_o,
    input wire logic irq_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_load;
        position_load_i;
    endsequence
    property p_irq;
        irq_o == |(raw_status_o & event_enable_i);
    endproperty
    property p_mask;
        masked_status_o == (raw_status_o & event_enable_i);
    endproperty
    property p_sel;
        status_o == (masked_status_select_i ? masked_status_o : raw_status_o);
    endproperty
    property p_load;
        s_load |=> position_o == $past(position_load_value_i);
    endproperty
    property p_stick;
        raw_status_o != 4'h0 |=> (~raw_status_o & $past(raw_status_o)
            & ~$past(event_clear_i)) == 4'h0;
    endproperty
    property p_velstop;
        !velocity_enable_i |=> $stable(velocity_o);
    endproperty
    property p_modoff;
        !module_enable_i |=> $stable(velocity_o);
    endproperty
    property p_tmr;
        !$stable(velocity_o) |-> raw_status_o[`EVT_VEL_TIMER];
    endproperty
    property p_perr;
        $rose(phase_error_o) |-> raw_status_o[`EVT_PHASE_ERROR];
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq wrong");
    a_mask: assert property (p_mask)
        else $error("masked wrong");
    a_sel: assert property (p_sel)
        else $error("status wrong");
    a_load: assert property (p_load)
        else $error("load wrong");
    a_stick: assert property (p_stick)
        else $error("event lost");
    a_velstop: assert property (p_velstop)
        else $error("velocity moved");
    a_modoff: assert property (p_modoff)
        else $error("velocity moved");
    a_tmr: assert property (p_tmr)
        else $error("no timer event");
    a_perr: assert property (p_perr)
        else $error("no error event");
endmodule
bind qei_core qei_core_chk #(.POS_W(POS_W), .VEL_W(VEL_W)) u_chk (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .module_enable_i(module_enable_i), .position_load_i(position_load_i),
    .position_load_value_i(position_load_value_i),
    .velocity_enable_i(velocity_enable_i), .event_enable_i(event_enable_i),
    .event_clear_i(event_clear_i),
    .masked_status_select_i(masked_status_select_i),
    .position_o(position_o), .velocity_o(velocity_o),
    .phase_error_o(phase_error_o), .raw_status_o(raw_status_o),
    .masked_status_o(masked_status_o), .status_o(status_o), .irq_o(irq_o));

// ==== dv/tb.sv ====
/* Testbench for qei_core driven by the encoder model.
   Assumes hw/ on the include path. */
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic en = 1'b0, both = 1'b1, rio = 1'b0, swp = 1'b0, ld = 1'b0;
    logic vel = 1'b0, msel = 1'b0, cdir = 1'b0;
    logic [2:0] pdiv = 3'h0;
    logic [31:0] ldv = 32'h0, per = 32'h258;
    logic [3:0] ien = 4'h0, clr = 4'h0;
    logic pa, pb, ix, dir, perr, iseen, irq;
    logic [31:0] pos, velo;
    logic [3:0] raw, msk, sts;
    int n_mismatch = 0, checks = 0;
    localparam logic [31:0] LIM = 32'h10;
    initial forever #10 clk = ~clk;
    qei_enc_model u_enc (.sys_clk_i(clk), .phase_a_o(pa), .phase_b_o(pb),
        .index_o(ix));
    qei_core u_dut (.sys_clk_i(clk), .rstn_i(rstn), .phase_a_input_i(pa),
        .phase_b_input_i(pb), .index_i(ix), .module_enable_i(en),
        .count_both_channels_i(both), .reset_on_index_i(rio),
        .clock_direction_decode_i(cdir), .channel_swap_i(swp),
        .position_upper_limit_i(LIM), .position_load_i(ld),
        .position_load_value_i(ldv), .velocity_enable_i(vel),
        .velocity_predivider_i(pdiv), .velocity_period_ticks_i(per),
        .event_enable_i(ien), .event_clear_i(clr),
        .masked_status_select_i(msel), .position_o(pos), .velocity_o(velo),
        .direction_o(dir), .phase_error_o(perr), .index_seen_o(iseen),
        .raw_status_o(raw), .masked_status_o(msk), .status_o(sts),
        .irq_o(irq));
    task cmp(input logic [31:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task steps(input int n, input bit fwd);
        repeat (n)
        begin
            u_enc.step(fwd);
            tick(3);
        end
        tick(4);
    endtask
    task pulse_clr(input logic [3:0] m);
        @(posedge clk);
        clr <= m;
        @(posedge clk);
        clr <= 4'h0;
        #1;
    endtask
    task load(input logic [31:0] v);
        @(posedge clk);
        ld <= 1'b1;
        ldv <= v;
        @(posedge clk);
        ld <= 1'b0;
        #1;
    endtask
    task wait_tmr;
        int k;
        k = 0;
        while (raw[2] !== 1'b1 && k < 1000)
        begin
            tick(1);
            k++;
        end
        cmp(k < 1000, 1);
    endtask
    task tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog, about three times the expected run
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish;
    end
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        en <= 1'b1;
        tick(1);
        cmp({pos, dir}, 32'h1);
        steps(5, 1);
        cmp(pos, 32'h5);
        steps(2, 0);
        cmp({pos, dir, raw[1]}, 32'hd);
        both <= 1'b0;
        steps(4, 1);
        cmp(pos, 32'h5);
        both <= 1'b1;
        steps(1, 1);
        swp <= 1'b1;
        steps(2, 1);
        cmp(pos, 32'h4);
        swp <= 1'b0;
        load(LIM);
        cmp(pos, LIM);
        steps(1, 1);
        cmp(pos, 32'h0);
        rio <= 1'b1;
        steps(2, 0);
        u_enc.idx;
        tick(6);
        cmp({pos, iseen}, {LIM, 1'b1});
        steps(3, 1);
        u_enc.idx;
        tick(6);
        cmp(pos, 32'h0);
        rio <= 1'b0;
        pulse_clr(4'hf);
        u_enc.glitch;
        tick(6);
        cmp({perr, raw[0], irq}, 32'h6);
        msel <= 1'b1;
        ien <= 4'h1;
        tick(1);
        cmp({pos, sts, irq}, 32'h3);
        pulse_clr(4'h1);
        cmp({perr, sts, irq}, 32'h0);
        for (int n = 0; n < 8; n++)
        begin
            vel <= 1'b0;
            pdiv <= n[2:0];
            pulse_clr(4'h4);
            vel <= 1'b1;
            steps(128, 1);
            wait_tmr;
            cmp(velo, 32'h80 >> n);
        end
        pulse_clr(4'h4);
        en <= 1'b0;
        steps(8, 1);
        tick(700);
        cmp({velo, raw[2]}, 32'h2);
        en <= 1'b1;
        vel <= 1'b0;
        tick(700);
        cmp(raw[2], 1'b0);
        vel <= 1'b1;
        wait_tmr;
        cmp(velo, 32'h0);
        // Clock-direction decode, rising A edges only, B sets direction
        both <= 1'b0;
        cdir <= 1'b1;
        load(32'h0);
        steps(4, 1);
        cmp(pos, 32'h1);
        steps(4, 0);
        cmp({pos, dir}, 32'h0);
        cmp({raw[1], msk, irq}, 32'h20);
        tally_and_finish;
    end
endmodule
